/* lsp_btn_model.sv */
// operator push button model for the panel bench
// assumes the bench calls push just after a rising clock edge
`default_nettype none
module lsp_btn_model (
	input wire logic clk,
	output var logic btn_mode_n,
	output var logic btn_set_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// button levels, released is high
	// ----------------------------------------
	initial begin
		btn_mode_n = 1'b1;
		btn_set_n = 1'b1;
	end
	task automatic push(input logic m, input logic s, input int cyc);
		btn_mode_n <= !m;
		btn_set_n <= !s;
		repeat (cyc) @(posedge clk);
		btn_mode_n <= 1'b1;
		btn_set_n <= 1'b1;
		@(posedge clk);
	endtask : push
endmodule : lsp_btn_model
`default_nettype wire

/* lsp_panel.sv */
// front panel indication and run-mode control of the level sensor
// assumes apb master on clk, buttons and short pins asynchronous, low active
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`include "lsp_regs.svh"
`default_nettype none
module lsp_panel #(
	parameter int unsigned P_INIT_CYC = `LSP_INIT_MS * `LSP_CLK_KHZ,
	parameter int unsigned P_VIEW_CYC = `LSP_VIEW_MS * `LSP_CLK_KHZ,
	parameter int unsigned P_UNLOCK_CYC = `LSP_UNLOCK_MS * `LSP_CLK_KHZ,
	parameter int unsigned P_DEB_CYC = `LSP_DEB_MS * `LSP_CLK_KHZ,
	parameter int unsigned P_LONG_CYC = `LSP_LONG_MS * `LSP_CLK_KHZ,
	parameter int unsigned P_FLASH_CYC = `LSP_FLASH_MS * `LSP_CLK_KHZ
) (
	input wire logic clk,
	input wire logic nrst,
	input wire lsp_pkg::lsp_apb_req_t apb,
	output logic pready,
	output logic pslverr,
	output logic [31:0] prdata,
	input wire logic btn_mode_n,
	input wire logic btn_set_n,
	input wire logic [3:0] short_n,
	output lsp_pkg::lsp_panel_t panel
);
	localparam logic [29:0] INIT_C = 30'(P_INIT_CYC);
	localparam logic [29:0] VIEW_C = 30'(P_VIEW_CYC);
	localparam logic [29:0] UNLK_C = 30'(P_UNLOCK_CYC);
	localparam logic [29:0] DEB_C = 30'(P_DEB_CYC);
	localparam logic [29:0] LONG_C = 30'(P_LONG_CYC);
	localparam logic [29:0] FLSH_C = 30'(P_FLASH_CYC);

	// ----------------------------------------
	// apb slave
	// ----------------------------------------
	function automatic logic reg_hit(input logic [7:0] a);
		reg_hit = (a == `LSP_OFS_CTRL) || (a == `LSP_OFS_LEVEL) ||
			(a == `LSP_OFS_PCT) || (a == `LSP_OFS_ZONE) ||
			(a == `LSP_OFS_FAULT) || (a == `LSP_OFS_PVAL) ||
			(a == `LSP_OFS_STAT);
	endfunction : reg_hit

	logic wr_en;
	logic [7:0] ctrl_q;
	logic [7:0] zone_q;
	logic [15:0] len_q;
	logic [15:0] pct_lvl_q;
	logic [15:0] pval_q [`LSP_NPARAM];
	logic [31:0] rd_d;
	logic [31:0] prdata_q;
	logic [3:0] err_q;
	logic [3:0] sc_s1;
	logic [3:0] sc_q;
	logic lock_q;
	logic pct_q;
	logic seen_q;
	logic [15:0] jump;
	logic unlock;
	lsp_pkg::lsp_state_t state_q;
	logic [2:0] pidx_q;

	assign pready = 1'b1;
	assign pslverr = apb.psel && apb.penable && !reg_hit(apb.paddr);
	assign wr_en = apb.psel && apb.penable && apb.pwrite;
	assign prdata = prdata_q;

	always_comb begin
		rd_d = 32'h0;
		case (apb.paddr)
			`LSP_OFS_CTRL: rd_d[7:0] = ctrl_q;
			`LSP_OFS_LEVEL: rd_d[15:0] = len_q;
			`LSP_OFS_PCT: rd_d[15:0] = pct_lvl_q;
			`LSP_OFS_ZONE: rd_d[7:0] = zone_q;
			`LSP_OFS_FAULT: rd_d[3:0] = err_q;
			`LSP_OFS_PVAL: rd_d[15:0] = pval_q[pidx_q];
			`LSP_OFS_STAT: begin
				rd_d[`LSP_STAT_ST +: 5] = state_q;
				rd_d[`LSP_STAT_PIDX +: 3] = pidx_q;
				rd_d[`LSP_STAT_LOCK] = lock_q;
				rd_d[`LSP_STAT_PCT] = pct_q;
				rd_d[`LSP_STAT_ERR +: 4] = err_q;
				rd_d[`LSP_STAT_SC +: 4] = sc_q;
			end
			default: rd_d = 32'h0;
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prdata_q <= 32'h0;
		end else if (apb.psel && !apb.penable && !apb.pwrite) begin
			prdata_q <= rd_d;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_q <= `LSP_CTRL_RST;
			zone_q <= `LSP_ZONE_RST;
			len_q <= 16'h0;
			pct_lvl_q <= 16'h0;
		end else if (wr_en) begin
			case (apb.paddr)
				`LSP_OFS_CTRL: ctrl_q <= apb.pwdata[7:0];
				`LSP_OFS_LEVEL: len_q <= apb.pwdata[15:0];
				`LSP_OFS_PCT: pct_lvl_q <= apb.pwdata[15:0];
				`LSP_OFS_ZONE: zone_q <= apb.pwdata[7:0];
				default: ;
			endcase
		end
	end

	// parameter values, writes rejected while locked
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < `LSP_NPARAM; i++) begin
				pval_q[i] <= 16'h0;
			end
		end else if (wr_en && apb.paddr == `LSP_OFS_PVAL && !lock_q) begin
			pval_q[apb.pwdata[`LSP_PVAL_IDX +: 3]] <= apb.pwdata[15:0];
		end
	end

	// ----------------------------------------
	// fault latching and plausibility
	// ----------------------------------------
	assign jump = (apb.pwdata[15:0] >= len_q) ?
		(apb.pwdata[15:0] - len_q) : (len_q - apb.pwdata[15:0]);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			seen_q <= 1'b0;
		end else if (wr_en && apb.paddr == `LSP_OFS_LEVEL) begin
			seen_q <= 1'b1;
		end
	end

	// only reset clears, nothing else lowers a bit
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			err_q <= 4'h0;
		end else begin
			if (wr_en && apb.paddr == `LSP_OFS_FAULT) begin
				err_q <= err_q | apb.pwdata[3:0];
			end
			if (wr_en && apb.paddr == `LSP_OFS_LEVEL && seen_q &&
				jump > `LSP_JUMP_MAX) begin
				err_q <= err_q | 4'h8;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sc_s1 <= 4'h0;
			sc_q <= 4'h0;
		end else begin
			sc_s1 <= ~short_n;
			sc_q <= sc_s1;
		end
	end

	// ----------------------------------------
	// buttons
	// ----------------------------------------
	logic [1:0] b_s1;
	logic [1:0] b_q;
	logic [1:0] b_old_q;
	logic [1:0] brief;
	logic [29:0] bcnt_q [2];
	logic [29:0] both_q;

	function automatic logic is_brief(input logic [29:0] c);
		is_brief = (c >= DEB_C) && (c < LONG_C);
	endfunction : is_brief

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			b_s1 <= 2'h0;
			b_q <= 2'h0;
			b_old_q <= 2'h0;
		end else begin
			b_s1 <= {~btn_set_n, ~btn_mode_n};
			b_q <= b_s1;
			b_old_q <= b_q;
		end
	end

	for (genvar g = 0; g < 2; g++) begin : g_btn
		always_ff @(posedge clk or negedge nrst) begin
			if (!nrst) begin
				bcnt_q[g] <= 30'h0;
			end else if (!b_q[g]) begin
				bcnt_q[g] <= 30'h0;
			end else if (bcnt_q[g] != LONG_C) begin
				bcnt_q[g] <= bcnt_q[g] + 30'h1;
			end
		end
		assign brief[g] = b_old_q[g] && !b_q[g] && is_brief(bcnt_q[g]);
	end

	assign unlock = (&b_q) && (both_q == UNLK_C - 30'h1);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			both_q <= 30'h0;
		end else if (!(&b_q) || unlock) begin
			both_q <= 30'h0;
		end else begin
			both_q <= both_q + 30'h1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			lock_q <= 1'b0;
		end else if (unlock) begin
			lock_q <= 1'b0;
		end else if (wr_en && apb.paddr == `LSP_OFS_CTRL) begin
			lock_q <= apb.pwdata[`LSP_CTRL_LOCK];
		end
	end

	// ----------------------------------------
	// operating state
	// ----------------------------------------
	logic [29:0] tmr_q;
	logic tmr_end;
	logic [1:0] ind_q;
	logic [29:0] ind_tmr_q;
	logic [29:0] fl_q;
	logic flash_q;

	assign tmr_end = (state_q == lsp_pkg::ST_INIT) ?
		(tmr_q == INIT_C - 30'h1) : (tmr_q == VIEW_C - 30'h1);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= lsp_pkg::ST_INIT;
			tmr_q <= 30'h0;
			pidx_q <= 3'h0;
		end else begin
			tmr_q <= tmr_q + 30'h1;
			case (state_q)
				lsp_pkg::ST_INIT: begin
					if (tmr_end) begin
						state_q <= lsp_pkg::ST_RUN;
						tmr_q <= 30'h0;
					end
				end
				lsp_pkg::ST_RUN: begin
					tmr_q <= 30'h0;
					if (brief[0] && !lock_q) begin
						state_q <= lsp_pkg::ST_BROWSE;
						pidx_q <= 3'h0;
					end else if (brief[1]) begin
						state_q <= lsp_pkg::ST_TYPE;
					end
				end
				lsp_pkg::ST_BROWSE: begin
					if (brief[0]) begin
						pidx_q <= pidx_q + 3'h1;
						tmr_q <= 30'h0;
					end else if (brief[1]) begin
						state_q <= lsp_pkg::ST_VIEW;
						tmr_q <= 30'h0;
					end else if (tmr_end) begin
						state_q <= lsp_pkg::ST_RUN;
					end
				end
				lsp_pkg::ST_VIEW: begin
					if (brief[0]) begin
						state_q <= lsp_pkg::ST_BROWSE;
						pidx_q <= pidx_q + 3'h1;
						tmr_q <= 30'h0;
					end else if (tmr_end) begin
						state_q <= lsp_pkg::ST_BROWSE;
						tmr_q <= 30'h0;
					end
				end
				lsp_pkg::ST_TYPE: begin
					if (brief[1]) begin
						tmr_q <= 30'h0;
					end else if (tmr_end) begin
						state_q <= lsp_pkg::ST_RUN;
					end
				end
				default: begin
					state_q <= lsp_pkg::ST_INIT;
					tmr_q <= 30'h0;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pct_q <= 1'b0;
		end else if (brief[1] && (state_q == lsp_pkg::ST_RUN ||
			state_q == lsp_pkg::ST_TYPE)) begin
			pct_q <= !pct_q;
		end
	end

	// lock/unlock banner: 1 = locked, 2 = unlocked
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ind_q <= 2'h0;
			ind_tmr_q <= 30'h0;
		end else if (unlock) begin
			ind_q <= 2'h2;
			ind_tmr_q <= 30'h0;
		end else if (brief[0] && lock_q && state_q == lsp_pkg::ST_RUN) begin
			ind_q <= 2'h1;
			ind_tmr_q <= 30'h0;
		end else if (ind_q != 2'h0) begin
			ind_tmr_q <= ind_tmr_q + 30'h1;
			if (ind_tmr_q == VIEW_C - 30'h1) begin
				ind_q <= 2'h0;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fl_q <= 30'h0;
			flash_q <= 1'b0;
		end else if (fl_q == FLSH_C - 30'h1) begin
			fl_q <= 30'h0;
			flash_q <= !flash_q;
		end else begin
			fl_q <= fl_q + 30'h1;
		end
	end

	// ----------------------------------------
	// display and outputs
	// ----------------------------------------
	lsp_pkg::lsp_panel_t pd;
	logic init;
	logic cfg;

	assign init = (state_q == lsp_pkg::ST_INIT);
	assign cfg = ctrl_q[`LSP_CTRL_CFG];

	always_comb begin
		pd = '0;
		pd.code = lsp_pkg::DC_NUM;
		if (init || !cfg) begin
			pd.sw_out = 3'h0;
		end else if (|err_q) begin
			pd.sw_out = ctrl_q[`LSP_CTRL_FOU +: 3];
		end else begin
			pd.sw_out = zone_q[`LSP_ZONE_SW +: 3];
		end
		pd.overflow_output = !init && cfg && !(|err_q) &&
			!zone_q[`LSP_ZONE_OP];
		pd.led[6:4] = pd.sw_out;
		pd.led[7] = pd.overflow_output;
		if (init) begin
			pd.code = lsp_pkg::DC_CAL;
		end else if (err_q[0]) begin
			pd.code = lsp_pkg::DC_ERR;
			pd.value = `LSP_E000;
		end else if (err_q[1]) begin
			pd.code = lsp_pkg::DC_ERR;
			pd.value = `LSP_E031;
		end else if (err_q[2]) begin
			pd.code = lsp_pkg::DC_ERR;
			pd.value = `LSP_E033;
		end else if (err_q[3]) begin
			pd.code = lsp_pkg::DC_ERR;
			pd.value = `LSP_E034;
		end else if (|sc_q) begin
			if ($countones(sc_q) > 1) begin
				pd.code = lsp_pkg::DC_SC_MULTI;
			end else if (sc_q[3]) begin
				pd.code = lsp_pkg::DC_OVERFLOW_SHORT_INDICATION;
			end else begin
				pd.code = lsp_pkg::DC_SC_OUT;
				pd.value = sc_q[0] ? 16'h1 : (sc_q[1] ? 16'h2 : 16'h3);
			end
			if (flash_q) begin
				pd.code = lsp_pkg::DC_BLANK;
			end
		end else if (ind_q != 2'h0) begin
			pd.code = ind_q[0] ? lsp_pkg::DC_LOC : lsp_pkg::DC_UNLOCKED_INDICATION;
		end else if (state_q == lsp_pkg::ST_BROWSE) begin
			pd.code = lsp_pkg::DC_PNAME;
			pd.value = {13'h0, pidx_q};
		end else if (state_q == lsp_pkg::ST_VIEW) begin
			pd.code = lsp_pkg::DC_PVAL;
			pd.value = pval_q[pidx_q];
		end else if (!cfg) begin
			pd.code = lsp_pkg::DC_NOCFG;
		end else if (zone_q[`LSP_ZONE_BELOW]) begin
			pd.code = lsp_pkg::DC_DASH;
		end else begin
			pd.value = pct_q ? pct_lvl_q : len_q;
			if (zone_q[`LSP_ZONE_FULL] && flash_q) begin
				pd.code = lsp_pkg::DC_FULL;
			end else begin
				pd.led[2:0] = pct_q ? 3'h4 :
					(ctrl_q[`LSP_CTRL_INCH] ? 3'h2 : 3'h1);
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			panel <= '0;
		end else begin
			panel <= pd;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	chk_init_cal: assert property (init |=> panel.code == lsp_pkg::DC_CAL)
		else $error("start-up pattern missing");
	chk_unit_led: assert property (!init &&
		panel.code == lsp_pkg::DC_NUM |-> $onehot(panel.led[2:0]))
		else $error("unit led not one-hot");
	chk_sw_led: assert property (!init && cfg && err_q == 4'h0 |=>
		panel.led[6:4] == $past(zone_q[`LSP_ZONE_SW +: 3]))
		else $error("output leds differ from outputs");
	chk_ovf_led: assert property (!init && cfg && err_q == 4'h0 |=>
		panel.led[7] == !$past(zone_q[`LSP_ZONE_OP]))
		else $error("overflow led differs");
	chk_nocfg_show: assert property (!init && !cfg && err_q == 4'h0 &&
		sc_q == 4'h0 && ind_q == 2'h0 && state_q == lsp_pkg::ST_RUN |=>
		panel.code == lsp_pkg::DC_NOCFG && panel.sw_out == 3'h0)
		else $error("unconfigured pattern missing");
	chk_unlock_hold: assert property (unlock |=> !lock_q ##0
		ind_q == 2'h2)
		else $error("unlock not taken");
	chk_browse_step: assert property (state_q == lsp_pkg::ST_BROWSE &&
		brief[0] |=> pidx_q == $past(pidx_q) + 3'h1)
		else $error("parameter step wrong");
	chk_view_time: assert property (state_q == lsp_pkg::ST_VIEW &&
		!brief[0] && tmr_q == VIEW_C - 30'h1 |=>
		state_q == lsp_pkg::ST_BROWSE)
		else $error("value view did not end");
	chk_e000_prio: assert property (!init && err_q[0] |=>
		panel.code == lsp_pkg::DC_ERR && panel.value == `LSP_E000)
		else $error("e000 not shown first");
	chk_err_sticky: assert property ((err_q & $past(err_q)) ==
		$past(err_q))
		else $error("latched error lost");
	chk_ovf_open: assert property (|err_q |=> !panel.overflow_output)
		else $error("overflow output closed in fault");

	cov_run_entry: cover property (init ##1 state_q == lsp_pkg::ST_RUN);
	cov_view: cover property (state_q == lsp_pkg::ST_VIEW);
	cov_unlock: cover property (lock_q ##1 unlock);
	cov_jump: cover property ($rose(err_q[3]));
endmodule : lsp_panel
`default_nettype wire

/* lsp_pkg.sv */
// types shared by the panel logic
// assumes nothing beyond a systemverilog compiler
`default_nettype none
package lsp_pkg;
	typedef enum logic [4:0] {
		ST_INIT = 5'h01,
		ST_RUN = 5'h02,
		ST_BROWSE = 5'h04,
		ST_VIEW = 5'h08,
		ST_TYPE = 5'h10
	} lsp_state_t;
	typedef enum logic [3:0] {
		DC_NUM = 4'h0, DC_DASH = 4'h1, DC_FULL = 4'h2, DC_CAL = 4'h3,
		DC_NOCFG = 4'h4, DC_LOC = 4'h5, DC_UNLOCKED_INDICATION = 4'h6, DC_PNAME = 4'h7,
		DC_PVAL = 4'h8, DC_ERR = 4'h9, DC_SC_OUT = 4'ha, DC_OVERFLOW_SHORT_INDICATION = 4'hb,
		DC_SC_MULTI = 4'hc, DC_BLANK = 4'hd
	} lsp_disp_t;
	typedef struct packed {
		lsp_disp_t code;
		logic [15:0] value;
		logic [7:0] led;
		logic [2:0] sw_out;
		logic overflow_output;
	} lsp_panel_t;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} lsp_apb_req_t;
endpackage : lsp_pkg
`default_nettype wire

/* lsp_regs.svh */
// register offsets, field positions, reset values and timing for the panel
// assumes a 40 MHz clock and a 32-bit apb bus
`ifndef LSP_REGS_SVH
`define LSP_REGS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define LSP_OFS_CTRL 8'h00
`define LSP_OFS_LEVEL 8'h04
`define LSP_OFS_PCT 8'h08
`define LSP_OFS_ZONE 8'h0c
`define LSP_OFS_FAULT 8'h10
`define LSP_OFS_PVAL 8'h14
`define LSP_OFS_STAT 8'h18
// ----------------------------------------
// field positions
// ----------------------------------------
`define LSP_CTRL_CFG 0
`define LSP_CTRL_LOCK 1
`define LSP_CTRL_INCH 2
`define LSP_CTRL_FOU 4
`define LSP_ZONE_BELOW 0
`define LSP_ZONE_FULL 1
`define LSP_ZONE_OP 2
`define LSP_ZONE_SW 4
`define LSP_PVAL_IDX 16
`define LSP_STAT_ST 0
`define LSP_STAT_PIDX 8
`define LSP_STAT_LOCK 12
`define LSP_STAT_PCT 13
`define LSP_STAT_ERR 16
`define LSP_STAT_SC 20
// ----------------------------------------
// reset values and limits
// ----------------------------------------
`define LSP_CTRL_RST 8'h00
`define LSP_ZONE_RST 8'h00
`define LSP_JUMP_MAX 16'h0100
`define LSP_NPARAM 8
// ----------------------------------------
// display error codes
// ----------------------------------------
`define LSP_E000 16'h0000
`define LSP_E031 16'h0031
`define LSP_E033 16'h0033
`define LSP_E034 16'h0034
// ----------------------------------------
// timing
// ----------------------------------------
`define LSP_CLK_KHZ 40000
`define LSP_INIT_MS 3000
`define LSP_VIEW_MS 15000
`define LSP_UNLOCK_MS 10000
`define LSP_DEB_MS 20
`define LSP_LONG_MS 1000
`define LSP_FLASH_MS 500
`endif

/* tb_level_sensor_panel_indicator.sv */
// self-checking bench for the level sensor front panel
// assumes lsp_pkg, lsp_regs.svh and the button model are compiled first
`include "lsp_regs.svh"
`default_nettype none
module tb_level_sensor_panel_indicator;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned INIT = 40;
	localparam int unsigned VIEW = 200;
	localparam int unsigned FLASH = 8;
	localparam logic [31:0] M_CODE = 32'hf0000000;
	localparam logic [31:0] M_ERR = 32'hfffff00f;
	localparam logic [32:0] M_ST = 33'h10000001f;
	logic clk;
	logic nrst;
	lsp_pkg::lsp_apb_req_t apb;
	logic pready;
	logic pslverr;
	logic [31:0] prdata;
	logic btn_mode_n;
	logic btn_set_n;
	logic [3:0] short_n;
	lsp_pkg::lsp_panel_t panel;
	logic look;
	int n_mismatch;
	int comparisons;
	int cyc;
	logic [65:0] q_exp[$];
	logic [65:0] note;
	logic [7:0] lvl;
	logic [2:0] sw;
	logic [15:0] ecode [3] = '{`LSP_E000, `LSP_E031, `LSP_E033};
	logic [3:0] sc_pat [3] = '{4'he, 4'h7, 4'hc};
	lsp_pkg::lsp_disp_t sc_code [3] = '{lsp_pkg::DC_SC_OUT,
		lsp_pkg::DC_OVERFLOW_SHORT_INDICATION, lsp_pkg::DC_SC_MULTI};

	lsp_panel #(.P_INIT_CYC(INIT), .P_VIEW_CYC(VIEW), .P_UNLOCK_CYC(100),
		.P_DEB_CYC(4), .P_LONG_CYC(20), .P_FLASH_CYC(FLASH)) dut_u (
		.clk(clk), .nrst(nrst), .apb(apb), .pready(pready),
		.pslverr(pslverr), .prdata(prdata), .btn_mode_n(btn_mode_n),
		.btn_set_n(btn_set_n), .short_n(short_n), .panel(panel));
	lsp_btn_model btn_u (.clk(clk), .btn_mode_n(btn_mode_n),
		.btn_set_n(btn_set_n));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = !clk;
	end
	// ----------------------------------------
	// compare, verdict and result watcher
	// ----------------------------------------
	task automatic chk(input logic [32:0] seen, input logic [32:0] exp,
		input logic [32:0] m);
		comparisons++;
		if ((seen & m) !== (exp & m)) begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen & m,
				exp & m);
		end
	endtask : chk
	task automatic close_out();
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : close_out
	always @(posedge clk) begin
		if (apb.psel && apb.penable && !apb.pwrite && pready === 1'b1) begin
			note = q_exp.pop_front();
			chk({pslverr, prdata}, note[32:0], note[65:33]);
		end
		if (look) begin
			note = q_exp.pop_front();
			chk({1'b0, panel}, note[32:0], note[65:33]);
		end
		cyc++;
		if (cyc > 5000) begin
			n_mismatch++;
			close_out();
		end
	end
	// ----------------------------------------
	// apb master, panel notes and buttons
	// ----------------------------------------
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge clk);
		apb.penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		apb <= '0;
		@(posedge clk);
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [32:0] e,
		input logic [32:0] m);
		q_exp.push_back({m, e});
		xfer(1'b0, a, 32'h0);
	endtask : rd
	task automatic pn(input logic [31:0] e, input logic [31:0] m);
		repeat (4) @(posedge clk);
		q_exp.push_back({1'b0, m, 1'b0, e});
		look <= 1'b1;
		@(posedge clk);
		look <= 1'b0;
	endtask : pn
	function automatic logic [31:0] pv(lsp_pkg::lsp_disp_t c,
		logic [15:0] v, logic [7:0] l, logic [2:0] s, logic o);
		return {c, v, l, s, o};
	endfunction : pv
	task automatic press(input logic m, input logic s);
		btn_u.push(m, s, 10);
		repeat (6) @(posedge clk);
	endtask : press
	task automatic alt(input lsp_pkg::lsp_disp_t a,
		input lsp_pkg::lsp_disp_t b);
		int na = 0;
		int nb = 0;
		repeat (3 * FLASH) begin
			@(posedge clk);
			na += int'(panel.code === a);
			nb += int'(panel.code === b);
		end
		chk({31'h0, na > 0, nb > 0}, 33'h3, 33'h3);
	endtask : alt
	task automatic rst();
		nrst <= 1'b0;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
	endtask : rst
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		nrst = 1'b0;
		apb = '0;
		short_n = 4'hf;
		look = 1'b0;
		n_mismatch = 0;
		comparisons = 0;
		cyc = 0;
		void'($urandom(64066));
		rst();
		pn(pv(lsp_pkg::DC_CAL, 16'h0, 8'h0, 3'h0, 1'b0), 32'hf000000f);
		repeat (INIT) @(posedge clk);
		rd(`LSP_OFS_STAT, 33'h02, M_ST);
		pn(pv(lsp_pkg::DC_NOCFG, 16'h0, 8'h0, 3'h0, 1'b0), 32'hf000000f);
		wr(`LSP_OFS_CTRL, 32'h1);
		for (int i = 0; i < 4; i++) begin
			lvl = 8'($urandom_range(255));
			sw = 3'($urandom);
			wr(`LSP_OFS_LEVEL, {24'h0, lvl});
			wr(`LSP_OFS_ZONE, {25'h0, sw, 4'h0});
			pn(pv(lsp_pkg::DC_NUM, {8'h0, lvl}, {1'b1, sw, 4'h1}, sw, 1'b1),
				32'hffffffff);
		end
		wr(`LSP_OFS_CTRL, 32'h5);
		pn(pv(lsp_pkg::DC_NUM, {8'h0, lvl}, {1'b1, sw, 4'h2}, sw, 1'b1),
			32'hffffffff);
		wr(`LSP_OFS_ZONE, 32'h4);
		pn(pv(lsp_pkg::DC_NUM, 16'h0, 8'h0, 3'h0, 1'b0), 32'hf000080f);
		wr(`LSP_OFS_ZONE, 32'h1);
		pn(pv(lsp_pkg::DC_DASH, 16'h0, 8'h0, 3'h0, 1'b1), 32'hf0000001);
		wr(`LSP_OFS_ZONE, 32'h2);
		alt(lsp_pkg::DC_FULL, lsp_pkg::DC_NUM);
		wr(`LSP_OFS_ZONE, 32'h0);
		press(1'b0, 1'b1);
		rd(`LSP_OFS_STAT, 33'h2010, 33'h10000201f);
		pn(pv(lsp_pkg::DC_NUM, 16'h0, 8'h04, 3'h0, 1'b0), 32'h70);
		press(1'b0, 1'b1);
		rd(`LSP_OFS_STAT, 33'h0010, 33'h10000201f);
		repeat (VIEW) @(posedge clk);
		rd(`LSP_OFS_STAT, 33'h02, M_ST);
		wr(`LSP_OFS_ZONE, 32'h0);
		press(1'b1, 1'b0);
		rd(`LSP_OFS_STAT, 33'h004, 33'h10000071f);
		press(1'b1, 1'b0);
		rd(`LSP_OFS_STAT, 33'h104, 33'h10000071f);
		press(1'b0, 1'b1);
		rd(`LSP_OFS_STAT, 33'h08, M_ST);
		pn(pv(lsp_pkg::DC_PVAL, 16'h0, 8'h0, 3'h0, 1'b0), M_CODE);
		repeat (VIEW) @(posedge clk);
		rd(`LSP_OFS_STAT, 33'h04, M_ST);
		repeat (VIEW) @(posedge clk);
		rd(`LSP_OFS_STAT, 33'h02, M_ST);
		wr(`LSP_OFS_CTRL, 32'h3);
		press(1'b1, 1'b0);
		pn(pv(lsp_pkg::DC_LOC, 16'h0, 8'h0, 3'h0, 1'b0), M_CODE);
		rd(`LSP_OFS_STAT, 33'h1002, 33'h10000101f);
		wr(`LSP_OFS_PVAL, 32'h00011234);
		rd(`LSP_OFS_PVAL, 33'h0, 33'h10000ffff);
		btn_u.push(1'b1, 1'b1, 110);
		rd(`LSP_OFS_STAT, 33'h0000, 33'h100001000);
		wr(`LSP_OFS_PVAL, 32'h00011234);
		rd(`LSP_OFS_PVAL, 33'h1234, 33'h10000ffff);
		pn(pv(lsp_pkg::DC_UNLOCKED_INDICATION, 16'h0, 8'h0, 3'h0, 1'b0), M_CODE);
		rd(8'h1c, 33'h100000000, 33'h1ffffffff);
		for (int i = 0; i < 3; i++) begin
			short_n <= sc_pat[i];
			repeat (4) @(posedge clk);
			alt(sc_code[i], lsp_pkg::DC_BLANK);
		end
		short_n <= 4'hf;
		wr(`LSP_OFS_CTRL, 32'h51);
		wr(`LSP_OFS_ZONE, 32'h20);
		wr(`LSP_OFS_LEVEL, 32'h20);
		wr(`LSP_OFS_LEVEL, 32'h180);
		pn(pv(lsp_pkg::DC_ERR, `LSP_E034, 8'h0, 3'h5, 1'b0), M_ERR);
		short_n <= 4'he;
		for (int i = 2; i >= 0; i--) begin
			wr(`LSP_OFS_FAULT, 32'h1 << i);
			pn(pv(lsp_pkg::DC_ERR, ecode[i], 8'h0, 3'h5, 1'b0),
				M_ERR);
		end
		short_n <= 4'hf;
		wr(`LSP_OFS_FAULT, 32'h0);
		rd(`LSP_OFS_FAULT, 33'hf, 33'h10000000f);
		rst();
		repeat (INIT + 5) @(posedge clk);
		wr(`LSP_OFS_CTRL, 32'h1);
		rd(`LSP_OFS_FAULT, 33'h0, 33'h10000000f);
		pn(pv(lsp_pkg::DC_NUM, 16'h0, 8'h0, 3'h0, 1'b0), M_CODE);
		close_out();
	end
endmodule : tb_level_sensor_panel_indicator
`default_nettype wire
